// *** fre_alu.sv ***
// Purpose: combinational result, flag and skip logic
// Assumes: operands already read from the file and work registers
// Notes:   outputs are valid in the execute cycle only
`timescale 1ns/10ps

module fre_alu
    import fre_pkg::*;
(
    // Operation and operands
    input  wire fre_pkg::fre_op_t op,
    input  wire logic [7:0]       work,
    input  wire logic [7:0]       fval,
    input  wire logic [7:0]       lit,
    input  wire logic [2:0]       bsel,
    input  wire logic             dbit,
    // Results
    output logic      [7:0]       res,
    output logic                  carry,
    output logic                  dcarry,
    output logic                  zero,
    output logic                  upd_carry,
    output logic                  upd_zero,
    output logic                  to_work,
    output logic                  to_file,
    output logic                  skip
);
    wire [8:0] sum9  = {1'b0, work} + {1'b0, fval};
    wire [4:0] low5  = {1'b0, work[3:0]} + {1'b0, fval[3:0]};
    wire [7:0] bmask = 8'(8'h01 << bsel);
    wire       bval  = |(fval & bmask);
    wire       dsel  = (op == OP_ADD) || (op == OP_AND_WORK_FILE) || (op == OP_MOVE_FILE);

    // Result select per class
    always_comb begin
        res = 8'h00;
        case (op)
            OP_ADD:   res = sum9[7:0];
            OP_AND_WORK_FILE: res = work & fval;
            OP_MOVE_FILE:  res = fval;
            OP_BCF:   res = fval & ~bmask;
            OP_BSF:   res = fval | bmask;
            OP_AND_LITERAL_WORK: res = work & lit;
            default:  res = 8'h00;
        endcase
    end

    // Carries out of bit 7 and bit 3, zero on all-zero result
    assign carry     = sum9[8];
    assign dcarry    = low5[4];
    assign zero      = (res == 8'h00);
    assign upd_carry = (op == OP_ADD);
    assign upd_zero  = dsel || (op == OP_AND_LITERAL_WORK);
    // Destination bit: 0 to work, 1 back to file
    assign to_work   = (dsel && !dbit) || (op == OP_AND_LITERAL_WORK);
    assign to_file   = (dsel && dbit) || (op == OP_BCF) || (op == OP_BSF);
    // Bit tests touch no flag
    assign skip      = ((op == OP_BTSC) && !bval) || ((op == OP_BTSS) && bval);

endmodule : fre_alu

// *** fre_core.sv ***
// Purpose: execute unit for file register, bit and literal instructions
// Assumes: APB master issues instructions by writing the instruction register
// Notes:   one execute cycle per instruction; a skip discards the next one
//
// Summary of operation
// - A read-modify-write of the I/O port uses pin levels, not the latch.
// - The direction load with operand 6 copies work into the port direction latches.
// - An instruction write to the timer register clears the prescaler when it is assigned there.
// - Add sums work and file, writes the destination and updates C, DC and Z.
// - Destination bit 0 selects the work register, 1 the addressed file register.
// - AND with file stores work AND file at the destination and updates only Z.
// - Bit clear forces the chosen bit of the file register to 0, flags untouched.
// - Bit set forces the chosen bit to 1, other bits keep the value read (pins on the port), flags untouched.
// - AND literal puts work AND an 8-bit literal into work and updates Z.
// - Test-skip-clear skips the next instruction when the tested bit is 0.
// - Test-skip-set skips when the bit is 1; neither test alters a flag.
// - A skip discards the next instruction written and runs a no-op instead.
//
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/10ps
`include "fre_params.svh"

module fre_core
    import fre_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // I/O port pins
    input  wire logic [7:0]  port_pin_in,
    output logic      [7:0]  port_out,
    output logic      [7:0]  port_oe,
    output logic      [7:0]  port_dir,
    // Timer prescaler side
    input  wire logic        psa_to_timer,
    output logic             prescaler_clear,
    // Sequencing side
    output logic             skip_taken
);

    // State and registers
    fre_state_t  state_q;
    fre_state_t  state_d;
    logic [11:0] instr_q;
    logic [7:0]  work_q;
    logic [7:0]  dir_q;
    logic [7:0]  result_q;
    logic [15:0] cycles_q;
    logic        carry_q;
    logic        dcarry_q;
    logic        zero_q;
    logic        skip_pend_q;
    logic        unsup_q;
    logic        cap_q;
    logic [31:0] prdata_q;
    logic        pclr_q;
    logic        skip_q;

    // Datapath wires
    wire [7:0] file_rd;
    wire [7:0] apb_file_rd;
    wire [7:0] alu_res;
    wire       alu_c;
    wire       alu_dc;
    wire       alu_z;
    wire       alu_upd_c;
    wire       alu_upd_z;
    wire       alu_to_w;
    wire       alu_to_f;
    wire       alu_skip;
    wire [7:0] port_latch;

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------

    // Register select, word aligned offsets
    wire [7:0] off      = paddr[7:0];
    wire       hi_zero  = (paddr[11:8] == 4'h0);
    wire       sel_ins  = hi_zero && (off == `FRE_OFF_INSTR);
    wire       sel_work = hi_zero && (off == `FRE_OFF_WORK);
    wire       sel_stat = hi_zero && (off == `FRE_OFF_STATUS);
    wire       sel_dir  = hi_zero && (off == `FRE_OFF_DIR);
    wire       sel_cyc  = hi_zero && (off == `FRE_OFF_CYCLES);
    wire       sel_res  = hi_zero && (off == `FRE_OFF_RESULT);
    wire       sel_file = hi_zero && (off[7] == 1'b1) && (off[1:0] == 2'b00);
    wire       sel_hit  = sel_ins || sel_work || sel_stat || sel_dir ||
                          sel_cyc || sel_res || sel_file;
    wire [4:0] apb_faddr = off[6:2];

    // Busy while an instruction executes
    wire       busy    = (state_q == ST_EXEC);

    // Wait states come only from a running execute cycle; a request that
    // meets it is held until the cycle after busy drops, one wait at most
    // Transfer completes at the edge where pready is seen high
    assign pready  = penable && cap_q;
    wire   xfer    = psel && penable && pready;
    wire   wr_xfer = xfer && pwrite;
    assign pslverr = pready && !sel_hit;
    assign prdata  = prdata_q;

    // Status word as read back
    wire [31:0] status_word = {26'h0, unsup_q, busy, skip_pend_q,
                               zero_q, dcarry_q, carry_q};

    // Read data select, unmapped reads as zero
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (sel_ins)       rd_mux = {20'h0, instr_q};
        else if (sel_work) rd_mux = {24'h0, work_q};
        else if (sel_stat) rd_mux = status_word;
        else if (sel_dir)  rd_mux = {24'h0, dir_q};
        else if (sel_cyc)  rd_mux = {16'h0, cycles_q};
        else if (sel_res)  rd_mux = {24'h0, result_q};
        else if (sel_file) rd_mux = {24'h0, apb_file_rd};
    end

    // Capture read data every cycle; ready only follows an idle cycle so results are never stale
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_q    <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            cap_q    <= psel && !busy && !xfer;
            prdata_q <= rd_mux;
        end
    end

    // ------------------------------------------------------------------
    // Execute datapath
    // ------------------------------------------------------------------

    // A pending skip turns the next instruction into a no-op
    wire fre_op_t op_raw = fre_decode(instr_q);
    wire fre_op_t op     = skip_pend_q ? OP_NOP : op_raw;
    wire [4:0]    faddr  = instr_q[4:0];
    wire          exec   = busy;

    fre_alu u_alu (
        .op        (op),
        .work      (work_q),
        .fval      (file_rd),
        .lit       (instr_q[7:0]),
        .bsel      (instr_q[7:5]),
        .dbit      (instr_q[5]),
        .res       (alu_res),
        .carry     (alu_c),
        .dcarry    (alu_dc),
        .zero      (alu_z),
        .upd_carry (alu_upd_c),
        .upd_zero  (alu_upd_z),
        .to_work   (alu_to_w),
        .to_file   (alu_to_f),
        .skip      (alu_skip)
    );

    // File write from execute or from software when idle
    // Software is held off while busy, so the two writers never collide
    wire       ex_fwr   = exec && alu_to_f;
    wire       apb_fwr  = wr_xfer && sel_file;
    wire       f_wr_en  = ex_fwr || apb_fwr;
    wire [4:0] f_wr_adr = ex_fwr ? faddr : apb_faddr;
    wire [7:0] f_wr_dat = ex_fwr ? alu_res : pwdata[7:0];

    fre_file u_file (
        .pclk       (pclk),
        .presetn    (presetn),
        .rd_a_addr  (faddr),
        .rd_a_data  (file_rd),
        .rd_b_addr  (apb_faddr),
        .rd_b_data  (apb_file_rd),
        .wr_en      (f_wr_en),
        .wr_addr    (f_wr_adr),
        .wr_data    (f_wr_dat),
        .pin_in     (port_pin_in),
        .port_latch (port_latch)
    );

    // Prescaler clear on an instruction write into the timer while the prescaler is assigned to it
    wire tmr_hit  = ex_fwr && (faddr == `FRE_TIMER_ADDR) && psa_to_timer;

    // Direction load only for the port operand
    wire dir_load = exec && (op == OP_DIR) &&
                    (instr_q[2:0] == `FRE_DIR_PORT_SEL);

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------

    // Idle until an instruction is written, then one execute cycle
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (wr_xfer && sel_ins) state_d = ST_EXEC;
            end
            ST_EXEC: state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Instruction register, loaded only when idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr_q <= `FRE_RST_INSTR;
        end else if (wr_xfer && sel_ins) begin
            instr_q <= pwdata[11:0];
        end
    end

    // Work register: execute result, or software write when idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            work_q <= `FRE_RST_WORK;
        end else if (exec && alu_to_w) begin
            work_q <= alu_res;
        end else if (wr_xfer && sel_work) begin
            work_q <= pwdata[7:0];
        end
    end

    // Flags: only the classes that own them update them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            carry_q  <= 1'b0;
            dcarry_q <= 1'b0;
            zero_q   <= 1'b0;
        end else if (exec) begin
            if (alu_upd_c) begin
                carry_q  <= alu_c;
                dcarry_q <= alu_dc;
            end
            if (alu_upd_z) zero_q <= alu_z;
        end else if (wr_xfer && sel_stat) begin
            carry_q  <= pwdata[`FRE_ST_CARRY];
            dcarry_q <= pwdata[`FRE_ST_DCARRY];
            zero_q   <= pwdata[`FRE_ST_ZERO];
        end
    end

    // Skip pending: set by a taken test, cleared by the discarded no-op
    // The discarded word cannot skip again, so discards never chain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            skip_pend_q <= 1'b0;
        end else if (exec) begin
            skip_pend_q <= !skip_pend_q && alu_skip;
        end
    end

    // Sticky unsupported flag; a status write of one clears it, event wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unsup_q <= 1'b0;
        end else if (exec && (op == OP_UNSUP)) begin
            unsup_q <= 1'b1;
        end else if (wr_xfer && sel_stat && pwdata[`FRE_ST_UNSUP]) begin
            unsup_q <= 1'b0;
        end
    end

    // Direction latches, reset to all inputs for safety
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_q <= `FRE_RST_DIR;
        end else if (dir_load) begin
            dir_q <= work_q;
        end
    end

    // Last result and instruction cycle count, discarded no-op included
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_q <= 8'h00;
            cycles_q <= 16'h0000;
        end else if (exec) begin
            result_q <= alu_res;
            cycles_q <= 16'(cycles_q + 16'h0001);
        end
    end

    // One-cycle side pulses, registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pclr_q <= 1'b0;
            skip_q <= 1'b0;
        end else begin
            pclr_q <= tmr_hit;
            skip_q <= exec && !skip_pend_q && alu_skip;
        end
    end

    // Pin side; a one in a direction bit floats the pin
    assign port_out        = port_latch;
    assign port_dir        = dir_q;
    assign port_oe         = ~dir_q;
    assign prescaler_clear = pclr_q;
    assign skip_taken      = skip_q;

endmodule : fre_core

// *** fre_core_props.sv ***
// Purpose: concurrent checks on the execute unit top ports
// Assumes: one clock domain, reset presetn active low
// Notes:   bound into fre_core below the module
`timescale 1ns/10ps
`include "fre_params.svh"

module fre_core_props (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB request and answer
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    // Port and side outputs
    input wire logic [7:0]  port_out,
    input wire logic [7:0]  port_oe,
    input wire logic [7:0]  port_dir,
    input wire logic        psa_to_timer,
    input wire logic        prescaler_clear,
    input wire logic        skip_taken
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Completed writes that launch an instruction or touch the port latch
    wire acc_instr = psel & penable & pready & pwrite & (paddr == 12'(`FRE_OFF_INSTR));
    wire acc_port  = psel & penable & pready & pwrite & (paddr == 12'(`FRE_FILE_BASE) + 12'h018);

    // Setup then access, and a one-cycle strobe
    sequence s_setup;
        psel && !penable ##1 psel && penable;
    endsequence
    sequence s_pulse(sig);
        sig ##1 !sig;
    endsequence

    property p_oe_inverse;
        port_oe == ~port_dir;
    endproperty
    property p_dir_src;
        $changed(port_dir) |-> $past(acc_instr, 2);
    endproperty
    property p_out_src;
        $changed(port_out) |-> $past(acc_port) || $past(acc_instr, 2);
    endproperty
    property p_pclr_src;
        prescaler_clear |-> $past(acc_instr, 2) && $past(psa_to_timer);
    endproperty
    property p_pclr_pulse;
        prescaler_clear |-> s_pulse(prescaler_clear);
    endproperty
    property p_skip_src;
        skip_taken |-> $past(acc_instr, 2);
    endproperty
    property p_skip_pulse;
        skip_taken |-> s_pulse(skip_taken);
    endproperty
    // Single execute cycle bounds the wait to one state; the check allows up to two
    property p_rdy_bound;
        s_setup |-> ##[0:2] pready;
    endproperty

    a_oe_inverse: assert property (p_oe_inverse) else $error("oe not inverse of dir");
    a_dir_src: assert property (p_dir_src) else $error("dir moved without instr");
    a_out_src: assert property (p_out_src) else $error("port latch moved unasked");
    a_pclr_src: assert property (p_pclr_src) else $error("stray prescaler clear");
    a_pclr_pulse: assert property (p_pclr_pulse) else $error("clear not one cycle");
    a_skip_src: assert property (p_skip_src) else $error("stray skip");
    a_skip_pulse: assert property (p_skip_pulse) else $error("skip not one cycle");
    a_rdy_bound: assert property (p_rdy_bound) else $error("pready too late");
endmodule : fre_core_props

bind fre_core fre_core_props u_props (
    .pclk            (pclk),
    .presetn         (presetn),
    .psel            (psel),
    .penable         (penable),
    .pwrite          (pwrite),
    .paddr           (paddr),
    .pready          (pready),
    .port_out        (port_out),
    .port_oe         (port_oe),
    .port_dir        (port_dir),
    .psa_to_timer    (psa_to_timer),
    .prescaler_clear (prescaler_clear),
    .skip_taken      (skip_taken)
);

// *** fre_core_tb_top.sv ***
// Purpose: self-checking bench for the execute unit over APB
// Assumes: pclk 25 MHz, pin levels driven by the bench
// Notes:   instructions are issued by writing the instruction register
`timescale 1ns/10ps
`include "fre_params.svh"

module fre_core_tb_top;
    import fre_pkg::*;

    localparam logic [11:0] adr_ins  = 12'(`FRE_OFF_INSTR);
    localparam logic [11:0] adr_work = 12'(`FRE_OFF_WORK);
    localparam logic [11:0] adr_st   = 12'(`FRE_OFF_STATUS);
    localparam logic [11:0] adr_dir  = 12'(`FRE_OFF_DIR);
    localparam logic [11:0] adr_cyc  = 12'(`FRE_OFF_CYCLES);

    logic        pclk, presetn, psel, penable, pwrite, psa_to_timer;
    logic        pready, pslverr, prescaler_clear, skip_taken, e, sk;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rv, cyc;
    logic [7:0]  port_pin_in, port_out, port_oe, port_dir;
    int          errors, comparisons, pclr_cnt, skip_cnt, n0;

    fre_core uut (
        .pclk            (pclk),
        .presetn         (presetn),
        .psel            (psel),
        .penable         (penable),
        .pwrite          (pwrite),
        .paddr           (paddr),
        .pwdata          (pwdata),
        .prdata          (prdata),
        .pready          (pready),
        .pslverr         (pslverr),
        .port_pin_in     (port_pin_in),
        .port_out        (port_out),
        .port_oe         (port_oe),
        .port_dir        (port_dir),
        .psa_to_timer    (psa_to_timer),
        .prescaler_clear (prescaler_clear),
        .skip_taken      (skip_taken)
    );

    // Clock, 40 ns period
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // Pulses last one cycle, so count them rather than poll
    always @(posedge pclk) begin
        if (prescaler_clear === 1'b1) pclr_cnt++;
        if (skip_taken === 1'b1) skip_cnt++;
    end

    function automatic logic [11:0] fa(input logic [4:0] f);
        return 12'(`FRE_FILE_BASE) + {5'h0, f, 2'b00};
    endfunction : fa

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        comparisons++;
        if (got !== ex) begin
            $display("[FAIL] %s expected %h seen %h", nm, ex, got);
            errors++;
        end
    endtask : chk

    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rv = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] ex);
        apb(1'b0, a, 32'h0);
        chk(nm, ex, rv);
    endtask : rdc

    // Issue, then let execute and the side pulse land
    task automatic ex_ins(input logic [11:0] ins);
        apb(1'b1, adr_ins, {20'h0, ins});
        repeat (3) @(posedge pclk);
    endtask : ex_ins

    // File operand 0x10; carry and digit carry preset to 1
    task automatic run_fw(input logic [11:0] base, input logic [7:0] w, input logic [7:0] fv,
                          input logic d);
        logic [8:0] s;
        logic [7:0] r;
        logic [2:0] st;
        apb(1'b1, fa(5'h10), {24'h0, fv});
        apb(1'b1, adr_work, {24'h0, w});
        apb(1'b1, adr_st, 32'h3);
        ex_ins(base | {6'h0, d, 5'h10});
        s = {1'b0, w} + {1'b0, fv};
        r = (base == 12'h1c0) ? s[7:0] : (w & fv);
        st = {r == 8'h00, 2'b11};
        if (base == 12'h1c0) st[1:0] = {({1'b0, w[3:0]} + {1'b0, fv[3:0]}) > 5'h0f, s[8]};
        rdc("work", adr_work, {24'h0, d ? w : r});
        rdc("file", fa(5'h10), {24'h0, d ? r : fv});
        rdc("flags", adr_st, {29'h0, st});
    endtask : run_fw

    task automatic complete_run();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run

    // Watchdog, far beyond the several hundred cycles needed
    initial begin
        #2000000;
        errors++;
        complete_run();
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        port_pin_in = 8'h0f;
        psa_to_timer = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        chk("port_oe", 32'h0, {24'h0, port_oe});
        rdc("dir", adr_dir, 32'hff);
        // Add and AND with file, both destinations, carry edges
        run_fw(12'h1c0, 8'h88, 8'h88, 1'b0);
        run_fw(12'h1c0, 8'h01, 8'hff, 1'b1);
        run_fw(12'h1c0, 8'h12, 8'h34, 1'b1);
        run_fw(12'h140, 8'hf0, 8'h0f, 1'b1);
        run_fw(12'h140, 8'h3c, 8'hf5, 1'b0);
        // AND literal with the all-ones literal and with 0x5a, which gives zero
        apb(1'b1, adr_work, 32'ha5);
        ex_ins(12'heff);
        rdc("and_literal_work", adr_work, 32'ha5);
        ex_ins(12'he5a);
        rdc("and_literal_work", adr_work, 32'h00);
        rdc("and_literal_work_z", adr_st, 32'h7);
        // Every bit number on the top file address
        for (int b = 0; b < 8; b++) begin
            apb(1'b1, fa(5'h1f), 32'hff);
            apb(1'b1, adr_st, 32'h7);
            ex_ins(12'h41f | {4'h0, 3'(b), 5'h0});
            rdc("bcf", fa(5'h1f), {24'h0, ~(8'h01 << b)});
            apb(1'b1, fa(5'h1f), 32'h0);
            ex_ins(12'h51f | {4'h0, 3'(b), 5'h0});
            rdc("bsf", fa(5'h1f), {24'h0, 8'h01 << b});
            rdc("bit_flags", adr_st, 32'h7);
        end
        // Bit tests on 0x04: clear/set variants, bits 2 and 3
        apb(1'b1, fa(5'h10), 32'h04);
        for (int i = 0; i < 4; i++) begin
            sk = (i == 1 || i == 2);
            n0 = skip_cnt;
            apb(1'b1, adr_work, 32'h5a);
            apb(1'b1, adr_st, 32'h3);
            apb(1'b0, adr_cyc, 32'h0);
            cyc = rv;
            ex_ins(((i < 2) ? 12'h610 : 12'h710) | (i[0] ? 12'h060 : 12'h040));
            chk("skip_taken", {31'h0, sk}, 32'(skip_cnt - n0));
            rdc("test_status", adr_st, {28'h0, sk, 3'b011});
            ex_ins(12'he00);
            rdc("discard", adr_work, sk ? 32'h5a : 32'h0);
            rdc("cycles", adr_cyc, cyc + 32'h2);
        end
        // Port rewrite reads pins, not the latch
        apb(1'b1, fa(5'h06), 32'hff);
        ex_ins(12'h5e6);
        chk("port_out", 32'h8f, {24'h0, port_out});
        ex_ins(12'h226);
        chk("move_port", 32'h0f, {24'h0, port_out});
        // Direction load acts on operand 6 only
        apb(1'b1, adr_work, 32'h3c);
        ex_ins(12'h006);
        chk("port_oe", 32'hc3, {24'h0, port_oe});
        chk("port_dir", 32'h3c, {24'h0, port_dir});
        apb(1'b1, adr_work, 32'h81);
        ex_ins(12'h005);
        rdc("dir", adr_dir, 32'h3c);
        // Timer writes clear the prescaler only when it is assigned
        psa_to_timer <= 1'b1;
        n0 = pclr_cnt;
        ex_ins(12'h501);
        ex_ins(12'h1c1);
        ex_ins(12'h1e1);
        psa_to_timer <= 1'b0;
        ex_ins(12'h501);
        chk("pclr", 32'h2, 32'(pclr_cnt - n0));
        // Opcode outside this unit raises the sticky flag only
        apb(1'b1, adr_st, 32'h0);
        ex_ins(12'hc00);
        rdc("unsup", adr_st, 32'h20);
        // Unmapped address is refused
        rdc("unmapped", 12'h100, 32'h0);
        chk("slverr", 32'h1, {31'h0, e});
        complete_run();
    end
endmodule : fre_core_tb_top

// *** fre_file.sv ***
// Purpose: 32 x 8 file register store with the I/O port mapped in
// Assumes: pin levels synchronous to pclk
// Notes:   port reads return pins, not the output latch
`timescale 1ns/10ps
`include "fre_params.svh"

module fre_file
    import fre_pkg::*;
(
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Read ports
    input  wire logic [4:0] rd_a_addr,
    output logic      [7:0] rd_a_data,
    input  wire logic [4:0] rd_b_addr,
    output logic      [7:0] rd_b_data,
    // Write port
    input  wire logic       wr_en,
    input  wire logic [4:0] wr_addr,
    input  wire logic [7:0] wr_data,
    // Port pins
    input  wire logic [7:0] pin_in,
    output logic      [7:0] port_latch
);
    logic [7:0] mem_q [0:31];

    // Storage, all locations cleared at reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 32; i++) mem_q[i] <= `FRE_RST_FILE;
        end else if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
        end
    end

    // Port location reads the pin levels
    assign rd_a_data  = (rd_a_addr == `FRE_PORT_ADDR) ? pin_in : mem_q[rd_a_addr];
    assign rd_b_data  = (rd_b_addr == `FRE_PORT_ADDR) ? pin_in : mem_q[rd_b_addr];
    assign port_latch = mem_q[`FRE_PORT_ADDR];

endmodule : fre_file

// *** fre_params.svh ***
// Purpose: constants for the file register execute unit
// Assumes: included by the package and by every module except fre_alu
// Notes:   offsets are APB byte addresses; file addresses are 5 bits
`ifndef FRE_PARAMS_SVH
`define FRE_PARAMS_SVH

// APB register offsets
`define FRE_OFF_INSTR      8'h00
`define FRE_OFF_WORK       8'h04
`define FRE_OFF_STATUS     8'h08
`define FRE_OFF_DIR        8'h0c
`define FRE_OFF_CYCLES     8'h10
`define FRE_OFF_RESULT     8'h14
`define FRE_FILE_BASE      8'h80

// Status register bit positions
`define FRE_ST_CARRY       0
`define FRE_ST_DCARRY      1
`define FRE_ST_ZERO        2
`define FRE_ST_SKIP        3
`define FRE_ST_BUSY        4
`define FRE_ST_UNSUP       5

// Special file addresses
`define FRE_PORT_ADDR      5'h06
`define FRE_TIMER_ADDR     5'h01
`define FRE_DIR_PORT_SEL   3'h6

// Reset values
`define FRE_RST_WORK       8'h00
`define FRE_RST_DIR        8'hff
`define FRE_RST_FILE       8'h00
`define FRE_RST_INSTR      12'h000

`endif

// *** fre_pkg.sv ***
// Purpose: types and opcode decode for the file register execute unit
// Assumes: 12-bit instruction words
// Notes:   opcodes outside this unit decode to an unsupported class
`include "fre_params.svh"

package fre_pkg;

    // Instruction classes handled here
    typedef enum logic [3:0] {
        OP_NOP   = 4'h0,
        OP_ADD   = 4'h1,
        OP_AND_WORK_FILE = 4'h2,
        OP_MOVE_FILE  = 4'h3,
        OP_BCF   = 4'h4,
        OP_BSF   = 4'h5,
        OP_BTSC  = 4'h6,
        OP_BTSS  = 4'h7,
        OP_AND_LITERAL_WORK = 4'h8,
        OP_DIR   = 4'h9,
        OP_UNSUP = 4'ha
    } fre_op_t;

    // Sequencer states, Gray along idle to execute
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_EXEC = 1'b1
    } fre_state_t;

    // Opcode field decode
    function automatic fre_op_t fre_decode(input logic [11:0] ins);
        fre_op_t op;
        op = OP_UNSUP;
        if (ins == 12'h000)                op = OP_NOP;
        else if (ins[11:6] == 6'h07)       op = OP_ADD;
        else if (ins[11:6] == 6'h05)       op = OP_AND_WORK_FILE;
        else if (ins[11:6] == 6'h08)       op = OP_MOVE_FILE;
        else if (ins[11:8] == 4'h4)        op = OP_BCF;
        else if (ins[11:8] == 4'h5)        op = OP_BSF;
        else if (ins[11:8] == 4'h6)        op = OP_BTSC;
        else if (ins[11:8] == 4'h7)        op = OP_BTSS;
        else if (ins[11:8] == 4'he)        op = OP_AND_LITERAL_WORK;
        else if (ins[11:3] == 9'h000)      op = OP_DIR;
        return op;
    endfunction : fre_decode

endpackage : fre_pkg
